// File: logic/axis_limit_map.vh
// register offsets, mode field positions, reset values and timing counts
`ifndef AXIS_LIMIT_MAP_VH
`define AXIS_LIMIT_MAP_VH

// apb byte offsets
`define OFS_AXIS_SELECT   8'h00
`define OFS_MODE          8'h04
`define OFS_DRIVE_CMD     8'h08
`define OFS_COMP_PLUS     8'h0c
`define OFS_COMP_MINUS    8'h10
`define OFS_ERROR_STATUS  8'h14
`define OFS_MAIN_STATUS   8'h18
`define OFS_LOGICAL_POS   8'h1c
`define OFS_REAL_POS      8'h20

// axis_limit_pulse_encoder_mode fields
`define MD_SOFT_PLUS_EN   0
`define MD_SOFT_MINUS_EN  1
`define MD_HARD_STOP_TYPE 2
`define MD_HARD_PLUS_POL  3
`define MD_HARD_MINUS_POL 4
`define MD_COMPARE_SRC    5
`define MD_PULSE_FORMAT   6
`define MD_PULSE_POL      7
`define MD_DIR_POL        8
`define MD_DECODE_TYPE    9
`define MD_QDIV_LO        10
`define MD_QDIV_HI        11
`define MD_FAULT_POL      12
`define MD_FAULT_EN       13
`define MD_INPOS_POL      14
`define MD_INPOS_EN       15
`define MODE_RESET        16'h0000

// axis_error_status fields
`define ES_SOFT_PLUS      0
`define ES_SOFT_MINUS     1
`define ES_HARD_PLUS      2
`define ES_HARD_MINUS     3
`define ES_FAULT          14

// drive command fields
`define DC_START_PLUS     0
`define DC_START_MINUS    1
`define DC_DECEL_STOP     2
`define DC_SUDDEN_STOP    3

// quadrature division codes
`define QDIV_1            2'h0
`define QDIV_2            2'h1
`define QDIV_4            2'h2

// timing
`define CLK_PERIOD_NS     8
`define PULSE_PERIOD_NS   80
`define PULSE_CYCLES      (`PULSE_PERIOD_NS / `CLK_PERIOD_NS)
`define PULSE_HIGH_CYCLES (`PULSE_CYCLES / 2)
`define DECEL_PULSES      4'h8

`endif

// File: logic/pin_sync.v
// two-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter W = 4
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // first stage feeds only the second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync_out = sync_r;

endmodule // pin_sync

// File: logic/axis_limit_pulse_encoder_config.v
// four-axis limit, pulse format, encoder and servo feedback logic with apb registers
`include "axis_limit_map.vh"

// Functional notes
// - mode word per axis, writes hit selected axes
// - plus soft limit: decel stop, set status
// - soft-limit status blocks same-direction drive commands
// - minus soft limit below lower compare, decel
// - hard limit stops, sudden or decelerating
// - hard limit input polarity per direction
// - compare source logical or real counter
// - pulse format two-pulse or pulse-direction
// - two-pulse: plus first pin, minus second
// - one-pulse: pulses first pin, direction second
// - drive pulse polarity positive or negative
// - direction output level per polarity bit
// - encoder decode quadrature or up/down
// - quadrature: a leads counts up
// - up/down: rising edges count up/down
// - quadrature division 1, 2, 4, invalid
// - servo fault input polarity
// - enabled fault sets status, stops drive
// - in-position input polarity
// - driving flag waits for in-position
// - mode words clear on reset
module axis_limit_pulse_encoder_config (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [3:0]  plus_hard_limit_input,
  input  wire [3:0]  minus_hard_limit_input,
  input  wire [3:0]  encoder_phase_a_or_up_input,
  input  wire [3:0]  encoder_phase_b_or_down_input,
  input  wire [3:0]  servo_fault_input,
  input  wire [3:0]  servo_settled_input,
  output wire [3:0]  first_pulse_output,
  output wire [3:0]  second_pulse_or_direction_output
);

  reg  [3:0]   sel_r;
  wire [3:0]   hp_s;
  wire [3:0]   hm_s;
  wire [3:0]   ea_s;
  wire [3:0]   eb_s;
  wire [3:0]   flt_s;
  wire [3:0]   inp_s;
  wire [15:0]  mode_w    [0:3];
  wire [15:0]  err_w     [0:3];
  wire [31:0]  lpos_w    [0:3];
  wire [31:0]  rpos_w    [0:3];
  wire [3:0]   drv_flag;
  wire         wr_en;
  wire         setup;
  reg  [1:0]   rd_axis;
  reg          addr_ok;
  reg  [31:0]  rd_val;

  // every pin passes two flops before use
  pin_sync #(.W(24)) u_sync (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_in       ({plus_hard_limit_input, minus_hard_limit_input,
                    encoder_phase_a_or_up_input, encoder_phase_b_or_down_input,
                    servo_fault_input, servo_settled_input}),
    .pin_sync_out ({hp_s, hm_s, ea_s, eb_s, flt_s, inp_s})
  );

  // apb strobes: zero wait states
  assign wr_en   = psel & penable & pwrite;
  assign setup   = psel & ~penable;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // address decode
  always @*
  begin
    case (paddr)
      `OFS_AXIS_SELECT, `OFS_MODE, `OFS_DRIVE_CMD, `OFS_COMP_PLUS,
      `OFS_COMP_MINUS, `OFS_ERROR_STATUS, `OFS_MAIN_STATUS,
      `OFS_LOGICAL_POS, `OFS_REAL_POS: addr_ok = 1'b1;
      default:                         addr_ok = 1'b0;
    endcase
  end

  // reads use the lowest selected axis
  always @*
  begin
    casez (sel_r)
      4'b???1: rd_axis = 2'h0;
      4'b??10: rd_axis = 2'h1;
      4'b?100: rd_axis = 2'h2;
      4'b1000: rd_axis = 2'h3;
      default: rd_axis = 2'h0;
    endcase
  end

  // read mux
  always @*
  begin
    case (paddr)
      `OFS_AXIS_SELECT:  rd_val = {28'h0000000, sel_r};
      `OFS_MODE:         rd_val = {16'h0000, mode_w[rd_axis]};
      `OFS_ERROR_STATUS: rd_val = {16'h0000, err_w[rd_axis]};
      `OFS_MAIN_STATUS:  rd_val = {28'h0000000, drv_flag};
      `OFS_LOGICAL_POS:  rd_val = lpos_w[rd_axis];
      `OFS_REAL_POS:     rd_val = rpos_w[rd_axis];
      default:           rd_val = 32'h00000000;
    endcase
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= rd_val;
  end

  // axis selection, kept until the next select write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_r <= 4'h0;
    else if (wr_en && paddr == `OFS_AXIS_SELECT)
      sel_r <= pwdata[3:0];
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : axis
      reg  [15:0] mode_r;
      reg  [31:0] cp_r;
      reg  [31:0] cm_r;
      reg  [31:0] lpos_r;
      reg  [31:0] rpos_r;
      reg         sp_r;
      reg         sm_r;
      reg         flt_r;
      reg         drv_r;
      reg         dir_r;
      reg         dec_r;
      reg  [3:0]  dcnt_r;
      reg  [3:0]  pcnt_r;
      reg         inw_r;
      reg         o1_r;
      reg         o2_r;
      reg         ea_r;
      reg         eb_r;
      wire        hit;
      wire        hp_a;
      wire        hm_a;
      wire        flt_a;
      wire        inp_a;
      wire [31:0] src;
      wire        ovp;
      wire        ovm;
      wire        hard;
      wire        cmd_p;
      wire        cmd_m;
      wire        sudden;
      wire        decel;
      wire        last;
      wire        step;
      wire        pul;
      wire        clr;
      wire [1:0]  qdiv;
      wire        qchg;
      wire        qup;
      wire        qcnt;
      reg         enc_inc;
      reg         enc_dec;

      assign hit   = sel_r[g];
      // polarity applied after synchronising
      assign hp_a  = ~(hp_s[g] ^ mode_r[`MD_HARD_PLUS_POL]);
      assign hm_a  = ~(hm_s[g] ^ mode_r[`MD_HARD_MINUS_POL]);
      assign flt_a = mode_r[`MD_FAULT_EN] & ~(flt_s[g] ^ mode_r[`MD_FAULT_POL]);
      assign inp_a = ~(inp_s[g] ^ mode_r[`MD_INPOS_POL]);

      // compare source and overrun checks
      assign src  = mode_r[`MD_COMPARE_SRC] ? rpos_r : lpos_r;
      assign ovp  = mode_r[`MD_SOFT_PLUS_EN] & drv_r & ~dir_r &
                    ($signed(src) > $signed(cp_r));
      assign ovm  = mode_r[`MD_SOFT_MINUS_EN] & drv_r & dir_r &
                    ($signed(src) < $signed(cm_r));
      assign hard = drv_r & (dir_r ? hm_a : hp_a);

      // drive command strobes
      assign cmd_p = wr_en && hit && paddr == `OFS_DRIVE_CMD && pwdata[`DC_START_PLUS];
      assign cmd_m = wr_en && hit && paddr == `OFS_DRIVE_CMD && pwdata[`DC_START_MINUS];
      assign sudden = flt_a | (hard & ~mode_r[`MD_HARD_STOP_TYPE]) |
                      (wr_en && hit && paddr == `OFS_DRIVE_CMD &&
                       pwdata[`DC_SUDDEN_STOP]);
      assign decel  = ovp | ovm | (hard & mode_r[`MD_HARD_STOP_TYPE]) |
                      (wr_en && hit && paddr == `OFS_DRIVE_CMD &&
                       pwdata[`DC_DECEL_STOP]);
      assign last = dec_r && dcnt_r == 4'h0;
      assign step = drv_r && pcnt_r == 4'h0 && !last;
      assign pul  = drv_r && pcnt_r < `PULSE_HIGH_CYCLES && !last;
      assign clr  = wr_en && hit && paddr == `OFS_ERROR_STATUS;

      // mode word and compare registers per axis
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          mode_r <= `MODE_RESET;
          cp_r   <= 32'h00000000;
          cm_r   <= 32'h00000000;
        end
        else if (wr_en && hit)
        begin
          if (paddr == `OFS_MODE)
            mode_r <= pwdata[15:0];
          if (paddr == `OFS_COMP_PLUS)
            cp_r <= pwdata;
          if (paddr == `OFS_COMP_MINUS)
            cm_r <= pwdata;
        end
      end

      // sticky error bits, set wins over clear
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sp_r  <= 1'b0;
          sm_r  <= 1'b0;
          flt_r <= 1'b0;
        end
        else
        begin
          sp_r  <= ovp | (sp_r & ~(clr & pwdata[`ES_SOFT_PLUS]));
          sm_r  <= ovm | (sm_r & ~(clr & pwdata[`ES_SOFT_MINUS]));
          flt_r <= flt_a | (flt_r & ~(clr & pwdata[`ES_FAULT]));
        end
      end

      // drive sequencer with sudden and decelerating stops
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          drv_r  <= 1'b0;
          dir_r  <= 1'b0;
          dec_r  <= 1'b0;
          dcnt_r <= 4'h0;
          pcnt_r <= 4'h0;
          inw_r  <= 1'b0;
          lpos_r <= 32'h00000000;
        end
        else
        begin
          if (inp_a)
            inw_r <= 1'b0;
          if (drv_r)
          begin
            if (sudden || (step && last))
            begin
              drv_r <= 1'b0;
              dec_r <= 1'b0;
              inw_r <= mode_r[`MD_INPOS_EN];
            end
            else
            begin
              if (decel && !dec_r)
              begin
                dec_r  <= 1'b1;
                dcnt_r <= `DECEL_PULSES;
              end
              pcnt_r <= (pcnt_r == `PULSE_CYCLES - 1) ? 4'h0 : pcnt_r + 4'h1;
              if (pcnt_r == 4'h0 && last)
              begin
                drv_r <= 1'b0;
                dec_r <= 1'b0;
                inw_r <= mode_r[`MD_INPOS_EN];
              end
              if (step)
              begin
                lpos_r <= dir_r ? lpos_r - 32'h1 : lpos_r + 32'h1;
                if (dec_r && dcnt_r != 4'h0)
                  dcnt_r <= dcnt_r - 4'h1;
              end
            end
          end
          else if (cmd_p && !sp_r && !flt_r && !hp_a)
          begin
            drv_r  <= 1'b1;
            dir_r  <= 1'b0;
            pcnt_r <= 4'h0;
            inw_r  <= 1'b0;
          end
          else if (cmd_m && !sm_r && !flt_r && !hm_a)
          begin
            drv_r  <= 1'b1;
            dir_r  <= 1'b1;
            pcnt_r <= 4'h0;
            inw_r  <= 1'b0;
          end
        end
      end

      // pulse pins formatted and registered
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          o1_r <= 1'b0;
          o2_r <= 1'b0;
        end
        else if (mode_r[`MD_PULSE_FORMAT])
        begin
          o1_r <= pul ^ mode_r[`MD_PULSE_POL];
          o2_r <= dir_r ^ mode_r[`MD_DIR_POL];
        end
        else
        begin
          o1_r <= (pul & ~dir_r) ^ mode_r[`MD_PULSE_POL];
          o2_r <= (pul & dir_r) ^ mode_r[`MD_PULSE_POL];
        end
      end

      // encoder decode
      assign qdiv = {mode_r[`MD_QDIV_HI], mode_r[`MD_QDIV_LO]};
      assign qchg = (ea_s[g] ^ ea_r) ^ (eb_s[g] ^ eb_r);
      assign qup  = ea_s[g] ^ eb_r;
      assign qcnt = (qdiv == `QDIV_1) ? qchg :
                    (qdiv == `QDIV_2) ? (ea_s[g] ^ ea_r) :
                    (qdiv == `QDIV_4) ? (ea_s[g] & ~ea_r) : 1'b0;

      // count direction per decode type
      always @*
      begin
        if (mode_r[`MD_DECODE_TYPE])
        begin
          enc_inc = ea_s[g] & ~ea_r;
          enc_dec = eb_s[g] & ~eb_r;
        end
        else
        begin
          enc_inc = qcnt & qup;
          enc_dec = qcnt & ~qup;
        end
      end

      // real position counter
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ea_r   <= 1'b0;
          eb_r   <= 1'b0;
          rpos_r <= 32'h00000000;
        end
        else
        begin
          ea_r <= ea_s[g];
          eb_r <= eb_s[g];
          if (enc_inc && !enc_dec)
            rpos_r <= rpos_r + 32'h1;
          else if (enc_dec && !enc_inc)
            rpos_r <= rpos_r - 32'h1;
        end
      end

      assign mode_w[g] = mode_r;
      assign err_w[g]  = {1'b0, flt_r, 10'h000, hm_a, hp_a, sm_r, sp_r};
      assign lpos_w[g] = lpos_r;
      assign rpos_w[g] = rpos_r;
      assign drv_flag[g] = drv_r | inw_r;
      assign first_pulse_output[g] = o1_r;
      assign second_pulse_or_direction_output[g] = o2_r;
    end
  endgenerate

endmodule // axis_limit_pulse_encoder_config

// File: testbench/axis_cfg_chk.sv
// port-level assertions for the axis configuration block
module axis_cfg_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [3:0]  first_pulse_output,
  input logic [3:0]  second_pulse_or_direction_output
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // zero-wait slave
  pready_high_a: assert property (pready)
    else $error("pready low");
  // error only in an access phase
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  // addresses past the map are refused
  unmapped_err_a: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
    else $error("unmapped access not refused");
  // mapped words never refused
  mapped_ok_a: assert property (
    psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  // a refused read returns zero
  err_read_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  // read data holds after the access
  rdata_hold_a: assert property (psel && penable && !pwrite |=> $stable(prdata))
    else $error("read data moved");
  // pulse starts at least nine cycles apart
  pulse_spacing_a: assert property (
    $rose(first_pulse_output[0]) |=> (!$rose(first_pulse_output[0]))[*8])
    else $error("pulse period too short");
  // pins quiet when reset lifts
  reset_quiet_a: assert property (
    $rose(presetn) |-> first_pulse_output == 4'h0 && second_pulse_or_direction_output == 4'h0)
    else $error("pins busy after reset");
endmodule // axis_cfg_chk

// File: testbench/motor_drive_model.sv
// motor driver with quadrature encoder and settled output
module motor_drive_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       one_pulse,
  input  logic [3:0] pulse_a,
  input  logic [3:0] pulse_b,
  output logic [3:0] enc_a,
  output logic [3:0] enc_b,
  output logic [3:0] settled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] q [4];
  logic [3:0] pa_q;
  logic [3:0] pb_q;
  int         quiet;

  // step the shaft per pulse; direction from pin pair or direction pin
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pa_q <= 4'h0;
      pb_q <= 4'h0;
      quiet <= 0;
      for (int g = 0; g < 4; g++)
        q[g] <= 2'h0;
    end
    else
    begin
      pa_q <= pulse_a;
      pb_q <= pulse_b;
      quiet <= ({pulse_a, pulse_b} != {pa_q, pb_q}) ? 0 : (quiet < 1000 ? quiet + 1 : quiet);
      for (int g = 0; g < 4; g++)
        if (pulse_a[g] && !pa_q[g])
          q[g] <= (one_pulse && pulse_b[g]) ? q[g] - 2'h1 : q[g] + 2'h1;
        else if (!one_pulse && pulse_b[g] && !pb_q[g])
          q[g] <= q[g] - 2'h1;
    end

  // phase a leads phase b when turning plus
  always_comb
    for (int g = 0; g < 4; g++)
    begin
      enc_a[g] = q[g][1] ^ q[g][0];
      enc_b[g] = q[g][1];
    end

  // settled after twenty quiet cycles, active high
  assign settled = {4{quiet >= 20}};
endmodule // motor_drive_model

// File: testbench/tb.sv
// testbench for the axis configuration block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        one_pulse, errv, fpo_q;
  logic [3:0]  lim_p, lim_m, enc_a, enc_b, fault, settled, fpo, spo;
  int          err_total, n_tests, cyc, stp, exp_pos, base;

  axis_limit_pulse_encoder_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .plus_hard_limit_input(lim_p),
    .minus_hard_limit_input(lim_m), .encoder_phase_a_or_up_input(enc_a),
    .encoder_phase_b_or_down_input(enc_b), .servo_fault_input(fault),
    .servo_settled_input(settled), .first_pulse_output(fpo),
    .second_pulse_or_direction_output(spo));

  motor_drive_model i_drv (.pclk(pclk), .presetn(presetn), .one_pulse(one_pulse),
    .pulse_a(fpo), .pulse_b(spo), .enc_a(enc_a), .enc_b(enc_b), .settled(settled));

  // clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // expected position from pulses seen, and hang guard
  always @(posedge pclk)
  begin
    fpo_q <= fpo[0];
    if (fpo[0] && !fpo_q)
      exp_pos <= exp_pos + stp;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer
  task bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll until axis 0 stops driving
  task wait_idle;
    rdv = 32'h1;
    for (int i = 0; i < 100 && rdv[0] !== 1'b0; i++)
      bus(8'h18, 32'h0, 1'b0);
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // test sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, one_pulse, fpo_q, errv, rdv} = '0;
    {stp, exp_pos, cyc, err_total, n_tests} = {32'h1, 128'h0};
    {lim_p, lim_m, fault} = 12'hfff;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    bus(8'h00, 32'h1, 1'b1);
    bus(8'h04, 32'h0, 1'b0);
    chk(rdv, 32'h0);
    bus(8'h00, 32'h2, 1'b1);
    bus(8'h04, 32'h1234, 1'b1);
    bus(8'h04, 32'h0, 1'b0);
    chk(rdv, 32'h1234);
    bus(8'h00, 32'h1, 1'b1);
    bus(8'h04, 32'h0, 1'b0);
    chk(rdv, 32'h0);
    bus(8'h24, 32'h0, 1'b0);
    chk({31'h0, errv}, 32'h1);
    $display("test registers done");
    bus(8'h0c, 32'h3, 1'b1);
    bus(8'h04, 32'h1, 1'b1);
    bus(8'h08, 32'h1, 1'b1);
    wait_idle;
    bus(8'h14, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h1);
    chk(32'(exp_pos > 3), 32'h1);
    bus(8'h1c, 32'h0, 1'b0);
    chk(rdv, 32'(exp_pos));
    bus(8'h20, 32'h0, 1'b0);
    chk(rdv, 32'(exp_pos));
    bus(8'h08, 32'h1, 1'b1);
    bus(8'h18, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h0);
    bus(8'h14, 32'h1, 1'b1);
    $display("test soft limit done");
    one_pulse <= 1'b1;
    stp <= -1;
    bus(8'h04, 32'h40, 1'b1);
    bus(8'h08, 32'h2, 1'b1);
    repeat (30) @(posedge pclk);
    chk({28'h0, spo}, 32'h1);
    bus(8'h08, 32'h8, 1'b1);
    wait_idle;
    bus(8'h20, 32'h0, 1'b0);
    chk(rdv, 32'(exp_pos));
    $display("test direction output done");
    // minus soft limit against the real counter: three steps cross, eight more decelerate
    bus(8'h20, 32'h0, 1'b0);
    base = rdv;
    bus(8'h10, 32'(base - 2), 1'b1);
    bus(8'h04, 32'h62, 1'b1);
    bus(8'h08, 32'h2, 1'b1);
    wait_idle;
    bus(8'h14, 32'h0, 1'b0);
    chk(rdv & 32'h2, 32'h2);
    bus(8'h20, 32'h0, 1'b0);
    chk(rdv, 32'(base - 11));
    bus(8'h1c, 32'h0, 1'b0);
    chk(rdv, 32'(exp_pos));
    bus(8'h14, 32'h2, 1'b1);
    $display("test minus soft limit done");
    one_pulse <= 1'b0;
    stp <= 1;
    bus(8'h04, 32'h2000, 1'b1);
    fault <= 4'he;
    repeat (5) @(posedge pclk);
    bus(8'h14, 32'h0, 1'b0);
    chk(rdv & 32'h4000, 32'h4000);
    bus(8'h08, 32'h1, 1'b1);
    bus(8'h18, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h0);
    fault <= 4'hf;
    // let the released pin pass the synchroniser, or the set wins over the clear
    repeat (5) @(posedge pclk);
    bus(8'h14, 32'h4000, 1'b1);
    bus(8'h14, 32'h0, 1'b0);
    chk(rdv & 32'h4000, 32'h0);
    $display("test servo fault done");
    // half-rate quadrature: nine steps count the phase a edges among them
    bus(8'h20, 32'h0, 1'b0);
    base = rdv;
    bus(8'h04, 32'h400, 1'b1);
    bus(8'h08, 32'h1, 1'b1);
    bus(8'h08, 32'h4, 1'b1);
    wait_idle;
    bus(8'h20, 32'h0, 1'b0);
    chk(rdv, 32'(base + 5 - (base & 1)));
    $display("test encoder division done");
    // hard limit turning active in mid-drive stops the axis
    bus(8'h04, 32'h0, 1'b1);
    bus(8'h08, 32'h1, 1'b1);
    repeat (12) @(posedge pclk);
    bus(8'h18, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h1);
    lim_p <= 4'he;
    repeat (5) @(posedge pclk);
    bus(8'h18, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h0);
    bus(8'h14, 32'h0, 1'b0);
    chk(rdv & 32'h4, 32'h4);
    bus(8'h08, 32'h1, 1'b1);
    bus(8'h18, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h0);
    lim_p <= 4'hf;
    bus(8'h04, 32'h8, 1'b1);
    repeat (5) @(posedge pclk);
    bus(8'h14, 32'h0, 1'b0);
    chk(rdv & 32'h4, 32'h4);
    $display("test hard limit done");
    bus(8'h04, 32'hc000, 1'b1);
    bus(8'h08, 32'h1, 1'b1);
    repeat (30) @(posedge pclk);
    bus(8'h08, 32'h8, 1'b1);
    bus(8'h18, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h1);
    repeat (60) @(posedge pclk);
    bus(8'h18, 32'h0, 1'b0);
    chk(rdv & 32'h1, 32'h0);
    $display("test in position done");
    // negative-logic pulses idle high on both pins in two-pulse format
    bus(8'h04, 32'h80, 1'b1);
    repeat (2) @(posedge pclk);
    chk({24'h0, spo, fpo} & 32'h11, 32'h11);
    $display("test pulse polarity done");
    tally_and_finish;
  end
endmodule // tb

bind axis_limit_pulse_encoder_config axis_cfg_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .first_pulse_output(first_pulse_output),
  .second_pulse_or_direction_output(second_pulse_or_direction_output));
